//--- verilog/bfc_host.sv
// Host controller that drives a byte-wide block flash through its pins.
`timescale 1ns/1ps
`default_nettype none
module bfc_host #(
  parameter int WAKE_READ_CYCLES = bfc_pkg::WAKE_READ_CYC,
  parameter int WAKE_WRITE_CYCLES = bfc_pkg::WAKE_WRITE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // User request side
  input wire logic req_valid,
  input wire bfc_pkg::bfc_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [bfc_pkg::DATA_W-1:0] rsp_data,
  // Powerdown control and device status
  input wire logic sleep_req,
  output logic flash_busy,
  output logic reads_array,
  // Flash pins
  output logic device_select_n,
  output logic output_drive_n,
  output logic write_strobe_n,
  output logic powerdown_reset_n,
  output logic [bfc_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [bfc_pkg::DATA_W-1:0] byte_lines_in,
  output logic [bfc_pkg::DATA_W-1:0] byte_lines_out,
  output logic byte_lines_oe,
  input wire logic ready_busy_n
);
  import bfc_pkg::*;

  typedef enum logic [2:0] {
    BFC_H_SLEEP = 3'b000,
    BFC_H_WAKE = 3'b001,
    BFC_H_IDLE = 3'b010,
    BFC_H_FIRST = 3'b011,
    BFC_H_SECOND = 3'b100,
    BFC_H_REPLY = 3'b101
  } bfc_hstate_t;

  // Pin inputs cross into mclk through two flops before anything reads them.
  logic [DATA_W-1:0] din_meta, din_sync;
  logic rb_meta, rb_sync;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      din_meta <= '0;
      din_sync <= '0;
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
    end else begin
      din_meta <= byte_lines_in;
      din_sync <= din_meta;
      rb_meta <= ready_busy_n;
      rb_sync <= rb_meta;
    end
  end

  bfc_hstate_t state, next_state;
  logic [15:0] wake_cnt, next_wake_cnt;
  logic read_ok, next_read_ok;
  bfc_req_t cur, next_cur;
  logic next_req_ready, next_rsp_valid, next_pd_n, next_busy, next_array;
  logic [DATA_W-1:0] next_rsp_data;
  logic cyc_start, cyc_write, cyc_done;
  logic [ADDR_W-1:0] cyc_addr;
  logic [DATA_W-1:0] cyc_wdata, cyc_rdata;
  bfc_pins_t cyc_pins;

  always_comb begin
    next_state = state;
    next_wake_cnt = wake_cnt;
    next_read_ok = read_ok;
    next_cur = cur;
    next_req_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_pd_n = powerdown_reset_n;
    next_busy = !rb_sync;
    next_array = reads_array;
    cyc_start = 1'b0;
    cyc_write = 1'b1;
    cyc_addr = cur.addr;
    cyc_wdata = cur.data;
    unique case (state)
      BFC_H_SLEEP: begin
        // Holding powerdown low also aborts any running erase or write.
        next_pd_n = 1'b0;
        if (!sleep_req) begin
          next_pd_n = 1'b1;
          next_wake_cnt = '0;
          next_read_ok = 1'b0;
          next_state = BFC_H_WAKE;
        end
      end
      BFC_H_WAKE: begin
        next_wake_cnt = wake_cnt + 1'b1;
        if (32'(wake_cnt) + 1 >= WAKE_READ_CYCLES) begin
          next_read_ok = 1'b1;
        end
        // Both wake times must have passed, whichever of the two is set longer.
        if (32'(wake_cnt) + 1 >= WAKE_WRITE_CYCLES &&
            (read_ok || 32'(wake_cnt) + 1 >= WAKE_READ_CYCLES)) begin
          next_array = 1'b1;
          next_req_ready = 1'b1;
          next_state = BFC_H_IDLE;
        end
      end
      BFC_H_IDLE: begin
        next_req_ready = 1'b1;
        if (sleep_req) begin
          next_req_ready = 1'b0;
          next_pd_n = 1'b0;
          next_state = BFC_H_SLEEP;
        end else if (req_valid && req_ready) begin
          next_req_ready = 1'b0;
          next_cur = req;
          next_state = BFC_H_FIRST;
        end
      end
      BFC_H_FIRST: begin
        cyc_start = 1'b1;
        unique case (cur.op)
          BFC_OP_READ: cyc_write = 1'b0;
          BFC_OP_CMD: begin
            next_array = (cur.data == CMD_READ_ARRAY);
          end
          BFC_OP_BYTE_WRITE: begin
            cyc_wdata = CMD_WRITE_SETUP;
            next_array = 1'b0;
          end
          BFC_OP_ERASE: begin
            cyc_wdata = CMD_ERASE_SETUP;
            next_array = 1'b0;
          end
          BFC_OP_SUSPEND: cyc_wdata = CMD_SUSPEND;
          BFC_OP_RESUME: cyc_wdata = CMD_CONFIRM;
          default: cyc_start = 1'b0;
        endcase
        // Any other op code is illegal and simply answered with no bus activity.
        next_state = cyc_start ? BFC_H_SECOND : BFC_H_REPLY;
      end
      BFC_H_SECOND: begin
        if (cyc_done) begin
          next_rsp_data = cyc_rdata;
          if (cur.op == BFC_OP_BYTE_WRITE || cur.op == BFC_OP_ERASE) begin
            // Second write carries the data or the erase confirm.
            cyc_start = 1'b1;
            cyc_wdata = (cur.op == BFC_OP_ERASE) ? CMD_CONFIRM : cur.data;
            next_cur.op = BFC_OP_CMD;
            next_cur.data = cyc_wdata;
          end else begin
            next_state = BFC_H_REPLY;
          end
        end
      end
      BFC_H_REPLY: begin
        next_rsp_valid = 1'b1;
        next_req_ready = 1'b1;
        next_state = BFC_H_IDLE;
      end
      default: next_state = BFC_H_SLEEP;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= BFC_H_SLEEP;
      wake_cnt <= '0;
      read_ok <= 1'b0;
      cur <= '0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      powerdown_reset_n <= 1'b0;
      flash_busy <= 1'b0;
      reads_array <= 1'b0;
    end else begin
      state <= next_state;
      wake_cnt <= next_wake_cnt;
      read_ok <= next_read_ok;
      cur <= next_cur;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      powerdown_reset_n <= next_pd_n;
      flash_busy <= next_busy;
      reads_array <= next_array;
    end
  end

  bfc_cycle u_cycle (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(cyc_start),
    .is_write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .byte_lines_sync(din_sync),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .pins(cyc_pins),
    .byte_lines_out(byte_lines_out),
    .byte_lines_oe(byte_lines_oe)
  );

  assign device_select_n = cyc_pins.device_select_n;
  assign output_drive_n = cyc_pins.output_drive_n;
  assign write_strobe_n = cyc_pins.write_strobe_n;
  assign flash_addr = cyc_pins.addr;
endmodule
`default_nettype wire

//--- verilog/bfc_pkg.sv
// Package of constants and types for the block flash host controller.
package bfc_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int BLOCK_SEL_W = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_READ_NS = 400;
  localparam int WAKE_WRITE_NS = 1000;
  localparam int WAKE_READ_CYC = (WAKE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_WRITE_CYC = (WAKE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = 4;
  localparam int SETUP_CYC = 2;
  localparam int HOLD_CYC = 2;
  localparam int READ_CYC = 10;
  localparam int CNT_W = 8;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_WRITE_SETUP_ALT = 8'h10;
  localparam logic [19:0] ID_MAKER_ADDR = 20'h00000;
  localparam logic [19:0] ID_DEVICE_ADDR = 20'h00001;
  localparam logic [19:0] BLOCK_OFS_MASK = 20'h0FFFF;

  // Host-level operations requested by the user side.
  typedef enum logic [2:0] {
    BFC_OP_READ = 3'b000,
    BFC_OP_CMD = 3'b001,
    BFC_OP_BYTE_WRITE = 3'b010,
    BFC_OP_ERASE = 3'b011,
    BFC_OP_SUSPEND = 3'b100,
    BFC_OP_RESUME = 3'b101
  } bfc_op_t;

  typedef struct packed {
    bfc_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bfc_req_t;

  // Flash pin group driven by the host.
  typedef struct packed {
    logic device_select_n;
    logic output_drive_n;
    logic write_strobe_n;
    logic powerdown_reset_n;
    logic [ADDR_W-1:0] addr;
  } bfc_pins_t;
endpackage

//--- verilog/bfc_cycle.sv
// Single asynchronous bus cycle sequencer for the flash pins.
`timescale 1ns/1ps
`default_nettype none
module bfc_cycle (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Cycle request
  input wire logic start,
  input wire logic is_write,
  input wire logic [bfc_pkg::ADDR_W-1:0] addr,
  input wire logic [bfc_pkg::DATA_W-1:0] wdata,
  input wire logic [bfc_pkg::DATA_W-1:0] byte_lines_sync,
  // Cycle result
  output logic done,
  output logic [bfc_pkg::DATA_W-1:0] rdata,
  output bfc_pkg::bfc_pins_t pins,
  output logic [bfc_pkg::DATA_W-1:0] byte_lines_out,
  output logic byte_lines_oe
);
  import bfc_pkg::*;

  typedef enum logic [1:0] {
    BFC_C_IDLE = 2'b00,
    BFC_C_SETUP = 2'b01,
    BFC_C_ACTIVE = 2'b10,
    BFC_C_HOLD = 2'b11
  } bfc_cstate_t;

  bfc_cstate_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic wr, next_wr;
  logic next_done;
  logic [DATA_W-1:0] next_rdata, next_out;
  logic next_oe;
  bfc_pins_t next_pins;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wr = wr;
    next_done = 1'b0;
    next_rdata = rdata;
    next_pins = pins;
    next_out = byte_lines_out;
    next_oe = byte_lines_oe;
    unique case (state)
      BFC_C_IDLE: begin
        if (start) begin
          next_wr = is_write;
          next_pins.addr = addr;
          next_pins.device_select_n = 1'b0;
          next_out = wdata;
          next_oe = is_write;
          next_cnt = CNT_W'(SETUP_CYC);
          next_state = BFC_C_SETUP;
        end
      end
      BFC_C_SETUP: begin
        if (cnt == '0) begin
          // Strobes only fall once address and select have settled.
          if (wr) begin
            next_pins.write_strobe_n = 1'b0;
            next_cnt = CNT_W'(STROBE_CYC);
          end else begin
            next_pins.output_drive_n = 1'b0;
            next_cnt = CNT_W'(READ_CYC);
          end
          next_state = BFC_C_ACTIVE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      BFC_C_ACTIVE: begin
        if (cnt == '0) begin
          if (!wr) begin
            next_rdata = byte_lines_sync;
          end
          // Address and data stay put across the strobe rise.
          next_pins.write_strobe_n = 1'b1;
          next_pins.output_drive_n = 1'b1;
          next_cnt = CNT_W'(HOLD_CYC);
          next_state = BFC_C_HOLD;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      BFC_C_HOLD: begin
        if (cnt == '0) begin
          next_pins.device_select_n = 1'b1;
          next_oe = 1'b0;
          next_done = 1'b1;
          next_state = BFC_C_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= BFC_C_IDLE;
      cnt <= '0;
      wr <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      pins <= '{device_select_n: 1'b1, output_drive_n: 1'b1, write_strobe_n: 1'b1,
                powerdown_reset_n: 1'b1, addr: '0};
      byte_lines_out <= '0;
      byte_lines_oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wr <= next_wr;
      done <= next_done;
      rdata <= next_rdata;
      pins <= next_pins;
      byte_lines_out <= next_out;
      byte_lines_oe <= next_oe;
    end
  end
endmodule
`default_nettype wire

//--- testbench/bfc_host_sva.sv
// Checker for the flash pin rules of the host controller.
`timescale 1ns/1ps
`default_nettype none
module bfc_host_chk #(parameter int WAKE_READ_CYCLES = 40, parameter int WAKE_WRITE_CYCLES = 100) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Status
  input wire logic flash_busy,
  input wire logic reads_array,
  // Flash pins
  input wire logic device_select_n,
  input wire logic output_drive_n,
  input wire logic write_strobe_n,
  input wire logic powerdown_reset_n,
  input wire logic [bfc_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [bfc_pkg::DATA_W-1:0] byte_lines_out,
  input wire logic byte_lines_oe,
  input wire logic ready_busy_n
);
  int wake;
  int next_wake;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // The count saturates so that a long run cannot wrap it back under the wake limits.
  always_comb next_wake = !powerdown_reset_n ? 0 : (wake < 1000 ? wake + 1 : wake);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) wake <= 0;
    else wake <= next_wake;
  end
  // A byte after a setup command is write data or a confirm, so an FFh there is no mode command.
  logic armed;
  logic strobe_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
      strobe_q <= 1'b1;
    end else begin
      strobe_q <= write_strobe_n;
      if (!powerdown_reset_n) armed <= 1'b0;
      else if (write_strobe_n && !strobe_q && !device_select_n) armed <= byte_lines_out inside {8'h40, 8'h10, 8'h20};
    end
  end
  sequence s_ff_cmd; $rose(write_strobe_n) && !device_select_n && !armed && byte_lines_out == 8'hFF; endsequence
  sequence s_rdy_low; !ready_busy_n [*5]; endsequence
  property p_rd_ctl; !output_drive_n |-> !device_select_n && write_strobe_n && !byte_lines_oe; endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("read controls wrong");
  property p_wr_ctl; !write_strobe_n |-> !device_select_n && output_drive_n && byte_lines_oe; endproperty
  a_wr_ctl: assert property (p_wr_ctl) else $error("write controls wrong");
  property p_latch; $rose(write_strobe_n) |-> $stable(flash_addr) && $stable(byte_lines_out) && byte_lines_oe; endproperty
  a_latch: assert property (p_latch) else $error("data moved at strobe rise");
  property p_wake_wr; !device_select_n |-> wake >= WAKE_WRITE_CYCLES; endproperty
  a_wake_wr: assert property (p_wake_wr) else $error("access too soon after wake");
  property p_wake_rd; !output_drive_n |-> wake >= WAKE_READ_CYCLES; endproperty
  a_wake_rd: assert property (p_wake_rd) else $error("read too soon after wake");
  property p_pd; !powerdown_reset_n |-> device_select_n && write_strobe_n && !byte_lines_oe; endproperty
  a_pd: assert property (p_pd) else $error("bus active in powerdown");
  property p_ff; s_ff_cmd |-> ##[1:20] reads_array; endproperty
  a_ff: assert property (p_ff) else $error("array mode not flagged");
  property p_busy; s_rdy_low |-> flash_busy; endproperty
  a_busy: assert property (p_busy) else $error("busy not reported");
endmodule
bind bfc_host bfc_host_chk #(.WAKE_READ_CYCLES(WAKE_READ_CYCLES), .WAKE_WRITE_CYCLES(WAKE_WRITE_CYCLES)) chk (
  .mclk, .rst_n, .flash_busy, .reads_array, .device_select_n, .output_drive_n, .write_strobe_n,
  .powerdown_reset_n, .flash_addr, .byte_lines_out, .byte_lines_oe, .ready_busy_n);
`default_nettype wire

//--- testbench/bfc_flash_model.sv
// Behavioural model of the byte-wide block flash device.
`timescale 1ns/1ps
`default_nettype none
module bfc_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h5A,
  parameter logic [7:0] DEVICE_ID = 8'h3C,
  parameter int WRITE_NS = 300,
  parameter int ERASE_NS = 3000
) (
  // Host pins
  input wire logic device_select_n,
  input wire logic output_drive_n,
  input wire logic write_strobe_n,
  input wire logic powerdown_reset_n,
  input wire logic [19:0] flash_addr,
  input wire logic [7:0] host,
  input wire logic host_oe,
  input wire logic vpp,
  // Device outputs
  output logic [7:0] byte_lines,
  output logic ready_busy_n
);
  // Identity codes above are arbitrary values.
  bit [7:0] mem [2**20];
  logic [1:0] mode;
  logic [1:0] pend;
  logic susp;
  logic [7:0] val;
  logic [7:0] last;
  realtime t_end;
  realtime left;
  wire drv = !device_select_n && !output_drive_n && write_strobe_n && powerdown_reset_n;
  assign val = mode == 2'd0 ? mem[flash_addr] : mode == 2'd1 ? (flash_addr[0] ? DEVICE_ID : MAKER_ID) :
    {ready_busy_n, susp, 6'h00};
  // A released bus shows the inverse of its last value so that a stale sample cannot pass.
  assign byte_lines = host_oe ? host : (drv ? val : ~last);
  always @* if (drv) last = val;
  task automatic start(input realtime ns);
    ready_busy_n = 1'b0;
    t_end = $realtime + ns;
  endtask
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {ready_busy_n, susp, pend, mode, last} = 14'h2000;
  end
  always @(negedge powerdown_reset_n) {ready_busy_n, susp, pend, mode} = 6'h20;
  // The timer ticks between rising clock edges so the busy pin never rises on a sampling edge when a timed operation ends.
  always #4 if (!ready_busy_n && $realtime >= t_end) ready_busy_n = 1'b1;
  always @(posedge write_strobe_n) begin
    if (!device_select_n && powerdown_reset_n) begin
      if (pend == 2'd1 && vpp) begin
        mem[flash_addr] = mem[flash_addr] & host;
        start(WRITE_NS);
      end
      if (pend == 2'd2 && vpp && host == 8'hD0) begin
        for (int i = 0; i < 65536; i++) mem[{flash_addr[19:16], 16'(i)}] = 8'hFF;
        start(ERASE_NS);
      end
      if (pend != 2'd0) begin
        mode = 2'd2;
        pend = 2'd0;
      end else case (host)
        8'hFF: if (ready_busy_n) mode = 2'd0;
        8'h90: mode = 2'd1;
        8'h70: mode = 2'd2;
        8'h20: pend = 2'd2;
        8'h40, 8'h10: pend = 2'd1;
        8'hB0: if (!ready_busy_n) begin
          left = t_end - $realtime;
          susp = 1'b1;
          ready_busy_n = 1'b1;
        end
        8'hD0: if (susp) begin
          susp = 1'b0;
          start(left);
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- testbench/bfc_host_tb_top.sv
// Self-checking bench for the block flash host controller.
`timescale 1ns/1ps
`default_nettype none
module bfc_host_tb_top;
  import bfc_pkg::*;
  logic mclk, rst_n, req_valid, req_ready, rsp_valid, sleep_req, flash_busy, reads_array, vpp_high;
  logic device_select_n, output_drive_n, write_strobe_n, powerdown_reset_n, byte_lines_oe, ready_busy_n;
  logic [19:0] flash_addr, a1, a2;
  logic [7:0] rsp_data, byte_lines_in, byte_lines_out, r, d1, d2;
  bfc_req_t req;
  int n_errors = 0;
  int num_checks = 0;
  bfc_host #(.WAKE_READ_CYCLES(2), .WAKE_WRITE_CYCLES(4)) DUT (.mclk, .rst_n, .req_valid, .req, .req_ready,
    .rsp_valid, .rsp_data, .sleep_req, .flash_busy, .reads_array, .device_select_n, .output_drive_n,
    .write_strobe_n, .powerdown_reset_n, .flash_addr, .byte_lines_in, .byte_lines_out, .byte_lines_oe, .ready_busy_n);
  bfc_flash_model #(.MAKER_ID(8'h5A), .DEVICE_ID(8'h3C)) flash (.device_select_n, .output_drive_n, .write_strobe_n,
    .powerdown_reset_n, .flash_addr, .host(byte_lines_out), .host_oe(byte_lines_oe), .vpp(vpp_high),
    .byte_lines(byte_lines_in), .ready_busy_n);
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc();
    @(posedge mclk);
    #1;
  endtask
  task automatic hang(input int i);
    if (i >= 2000) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic wait_busy(input logic v);
    int i;
    for (i = 0; i < 2000 && flash_busy !== v; i++) cyc();
    hang(i);
  endtask
  task automatic op(input bfc_op_t o, input logic [19:0] a, input logic [7:0] d);
    int i;
    for (i = 0; i < 2000 && req_ready !== 1'b1; i++) cyc();
    hang(i);
    req_valid = 1'b1;
    req = '{o, a, d};
    cyc();
    req_valid = 1'b0;
    for (i = 0; i < 2000 && rsp_valid !== 1'b1; i++) cyc();
    hang(i);
    r = rsp_data;
  endtask
  function automatic logic [7:0] stat(input logic busy, input logic susp);
    return {!busy, susp, 6'h00};
  endfunction
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {rst_n, req_valid, sleep_req, vpp_high, req} = '0;
    vpp_high = 1'b1;
    void'($urandom(32'h2751));
    repeat (20) @(posedge mclk);
    #1 rst_n = 1'b1;
    a1 = 20'($urandom);
    a2 = a1 ^ 20'h80000;
    d1 = 8'($urandom_range(0, 254));
    d2 = 8'($urandom_range(0, 254));
    op(BFC_OP_READ, a1, 8'h00);
    chk(r, 8'hFF);
    chk({7'h00, reads_array}, 8'h01);
    $display("test 1 done");
    op(BFC_OP_CMD, a1, CMD_IDENT);
    chk({7'h00, reads_array}, 8'h00);
    op(BFC_OP_READ, ID_MAKER_ADDR, 8'h00);
    chk(r, 8'h5A);
    op(BFC_OP_READ, ID_DEVICE_ADDR, 8'h00);
    chk(r, 8'h3C);
    op(bfc_op_t'(3'h6), a1, 8'h00);
    chk(r, 8'h3C);
    $display("test 2 done");
    op(BFC_OP_BYTE_WRITE, a1, d1);
    wait_busy(1'b1);
    wait_busy(1'b0);
    op(BFC_OP_CMD, a2, CMD_WRITE_SETUP_ALT);
    op(BFC_OP_CMD, a2, d2);
    wait_busy(1'b1);
    wait_busy(1'b0);
    op(BFC_OP_CMD, a1, CMD_READ_ARRAY);
    op(BFC_OP_READ, a1, 8'h00);
    chk(r, d1);
    op(BFC_OP_READ, a2, 8'h00);
    chk(r, d2);
    $display("test 3 done");
    vpp_high = 1'b0;
    op(BFC_OP_BYTE_WRITE, a1 ^ 20'h1, 8'h00);
    op(BFC_OP_CMD, a1, CMD_READ_STATUS);
    op(BFC_OP_READ, a1, 8'h00);
    chk(r, stat(1'b0, 1'b0));
    op(BFC_OP_CMD, a1, CMD_READ_ARRAY);
    op(BFC_OP_READ, a1 ^ 20'h1, 8'h00);
    chk(r, 8'hFF);
    vpp_high = 1'b1;
    $display("test 4 done");
    op(BFC_OP_ERASE, a1, 8'h00);
    wait_busy(1'b1);
    op(BFC_OP_SUSPEND, a1, 8'h00);
    wait_busy(1'b0);
    op(BFC_OP_CMD, a1, CMD_READ_STATUS);
    op(BFC_OP_READ, a1, 8'h00);
    chk(r, stat(1'b0, 1'b1));
    op(BFC_OP_CMD, a1, CMD_READ_ARRAY);
    op(BFC_OP_READ, a2, 8'h00);
    chk(r, d2);
    op(BFC_OP_RESUME, a1, 8'h00);
    wait_busy(1'b1);
    wait_busy(1'b0);
    op(BFC_OP_CMD, a1, CMD_READ_ARRAY);
    op(BFC_OP_READ, a1, 8'h00);
    chk(r, 8'hFF);
    $display("test 5 done");
    op(BFC_OP_ERASE, a2, 8'h00);
    wait_busy(1'b1);
    sleep_req = 1'b1;
    wait_busy(1'b0);
    chk({7'h00, powerdown_reset_n}, 8'h00);
    sleep_req = 1'b0;
    op(BFC_OP_READ, a1, 8'h00);
    chk(r, 8'hFF);
    chk({7'h00, reads_array}, 8'h01);
    op(BFC_OP_CMD, a1, CMD_READ_STATUS);
    op(BFC_OP_READ, a1, 8'h00);
    chk(r, stat(1'b0, 1'b0));
    $display("test 6 done");
    end_of_test();
  end
endmodule
`default_nettype wire
